// file: core/reset_seq_pkg.sv
package reset_seq_pkg;

    // clock rate in kHz
    localparam int unsigned CLK_KHZ          = 40000;
    // debounce time on the reset request input, in ms
    localparam int unsigned DEBOUNCE_MS      = 8000;
    localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_MS * CLK_KHZ;
    // delay from recognised request to internal reset, in ms
    localparam int unsigned RESET_DELAY_MS   = 500;
    localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_MS * CLK_KHZ;
    // length of the internal reset pulse
    localparam int unsigned RESET_PULSE_CYCLES = 16;
    localparam int unsigned CNT_W            = 32;

    // io configuration command value that selects the reset output
    localparam logic [7:0] IO_CFG_PIN        = 8'h06;
    localparam logic [7:0] IO_CFG_RESET_OUT  = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_DEBOUNCE = 3'b001,
        ST_DELAY    = 3'b010,
        ST_RESET    = 3'b011,
        ST_OFF      = 3'b100,
        ST_POWERUP  = 3'b101
    } seq_state_e;

    typedef struct packed {
        logic [7:0] pin;
        logic [7:0] value;
    } io_cfg_s;

    typedef struct packed {
        seq_state_e       state;
        logic [CNT_W-1:0] count;
        logic             reqMeta;
        logic             reqSync;
        logic             resetOutSel;
        logic             resetPulse;
        logic             poweredOff;
        logic             powerMeta;
        logic             powerSync;
        logic             periphHold;
    } seq_s;

endpackage

// file: core/reset_in_out_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module reset_in_out_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES,
    parameter int unsigned DELAY_LEN    = RESET_DELAY_CYCLES
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // reset request pin, low active, from the host
    input  wire logic resetReq_b,
    output logic      resetReqPullUp,
    // power-on level pin, low active
    input  wire logic powerOn_b,
    // power-up sequence done, from the power controller
    input  wire logic powerUpDone,
    // io configuration command
    input  wire logic    ioCfgValid,
    input  wire io_cfg_s ioCfg,
    // internal reset, memory clear and power-off request
    output logic      sysResetPulse,
    output logic      memClear,
    output logic      powerOff,
    // shared general io six pin
    input  wire logic gpioOut,
    input  wire logic gpioOe,
    output logic      pinOut,
    output logic      pinOe,
    output logic      periphReset_b
);

    seq_s cur;
    seq_s next_cur;

    // every state that keeps the peripherals in reset
    function automatic logic holds_periph(input seq_state_e s);
        return (s == ST_RESET) || (s == ST_OFF) || (s == ST_POWERUP);
    endfunction

    assign resetReqPullUp = 1'b1;

    always_comb begin
        next_cur = cur;
        next_cur.reqMeta = resetReq_b;
        next_cur.reqSync = cur.reqMeta;
        // the power-on level is a pin too, so it is synchronised as well
        next_cur.powerMeta = powerOn_b;
        next_cur.powerSync = cur.powerMeta;
        next_cur.resetPulse = 1'b0;
        if (ioCfgValid && ioCfg.pin == IO_CFG_PIN) begin
            next_cur.resetOutSel = (ioCfg.value == IO_CFG_RESET_OUT);
        end
        case (cur.state)
            ST_RUN: begin
                next_cur.count = '0;
                if (!cur.reqSync) begin
                    next_cur.state = ST_DEBOUNCE;
                    next_cur.count = CNT_W'(1);
                end
            end
            ST_DEBOUNCE: begin
                if (cur.reqSync) begin
                    // a release before the full time starts over
                    next_cur.state = ST_RUN;
                    next_cur.count = '0;
                end else if (cur.count >= CNT_W'(DEBOUNCE_LEN)) begin
                    next_cur.state = ST_DELAY;
                    next_cur.count = CNT_W'(1);
                end else begin
                    next_cur.count = cur.count + CNT_W'(1);
                end
            end
            ST_DELAY: begin
                // once recognised the request is committed
                if (cur.count >= CNT_W'(DELAY_LEN)) begin
                    next_cur.state = ST_RESET;
                    next_cur.count = CNT_W'(1);
                    next_cur.resetPulse = 1'b1;
                end else begin
                    next_cur.count = cur.count + CNT_W'(1);
                end
            end
            ST_RESET: begin
                next_cur.resetPulse = 1'b1;
                if (cur.count >= CNT_W'(RESET_PULSE_CYCLES)) begin
                    next_cur.count = '0;
                    next_cur.resetPulse = 1'b0;
                    if (cur.powerSync) begin
                        next_cur.state = ST_OFF;
                        next_cur.poweredOff = 1'b1;
                    end else begin
                        next_cur.state = ST_POWERUP;
                    end
                end else begin
                    next_cur.count = cur.count + CNT_W'(1);
                end
            end
            ST_OFF: begin
                // leaves only when the power-on input is asserted
                if (!cur.powerSync) begin
                    next_cur.state = ST_POWERUP;
                    next_cur.poweredOff = 1'b0;
                end
            end
            ST_POWERUP: begin
                if (powerUpDone) begin
                    next_cur.state = ST_RUN;
                end
            end
            default: begin
                next_cur.state = ST_RUN;
                next_cur.count = '0;
            end
        endcase
        // registered so a state change cannot glitch the peripherals' reset
        next_cur.periphHold = holds_periph(next_cur.state);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur.state       <= ST_POWERUP;
            cur.count       <= '0;
            cur.reqMeta     <= 1'b1;
            cur.reqSync     <= 1'b1;
            cur.resetOutSel <= 1'b0;
            cur.resetPulse  <= 1'b0;
            cur.poweredOff  <= 1'b0;
            cur.powerMeta   <= 1'b1;
            cur.powerSync   <= 1'b1;
            cur.periphHold  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign sysResetPulse = cur.resetPulse;
    assign memClear      = cur.resetPulse;
    assign powerOff      = cur.poweredOff;
    assign periphReset_b = !cur.periphHold;
    // pin follows the general io until configured as reset output
    assign pinOut = cur.resetOutSel ? periphReset_b : gpioOut;
    assign pinOe  = cur.resetOutSel ? 1'b1 : gpioOe;

    a_debounce_restart: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_DEBOUNCE && cur.reqSync) |=> cur.state == ST_RUN)
        else $error("debounce did not restart on release");
    a_sync_depth: assert property (
        @(posedge clk) disable iff (!rst_b)
        cur.reqSync == $past(resetReq_b, 2))
        else $error("request input not seen through two flops");
    a_debounce_full: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_DEBOUNCE && $past(cur.state) != ST_DEBOUNCE)
        |-> cur.count == CNT_W'(1))
        else $error("debounce count not started at one");
    a_debounce_count: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_DEBOUNCE && !cur.reqSync
         && cur.count < CNT_W'(DEBOUNCE_LEN))
        |=> cur.state == ST_DEBOUNCE)
        else $error("request recognised before the debounce time");
    a_delay_entry: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_DELAY && $past(cur.state) == ST_DEBOUNCE)
        |-> $past(cur.count) >= CNT_W'(DEBOUNCE_LEN))
        else $error("request recognised early");
    a_delay_committed: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_DELAY && cur.count < CNT_W'(DELAY_LEN))
        |=> cur.state == ST_DELAY)
        else $error("delay left before its length");
    a_delay_length: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_RESET && $past(cur.state) == ST_DELAY)
        |-> $past(cur.count) >= CNT_W'(DELAY_LEN))
        else $error("internal reset before delay");
    a_pulse_only_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        cur.state != ST_RESET |-> !sysResetPulse)
        else $error("internal reset outside the reset phase");
    a_reset_pulse: assert property (
        @(posedge clk) disable iff (!rst_b)
        $rose(cur.state == ST_RESET) |-> sysResetPulse && memClear)
        else $error("reset entry without pulse");
    a_pulse_held: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_RESET && cur.count < CNT_W'(RESET_PULSE_CYCLES))
        |=> cur.state == ST_RESET && sysResetPulse && memClear)
        else $error("reset pulse cut short");
    a_power_choice: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_RESET && cur.count >= CNT_W'(RESET_PULSE_CYCLES))
        |=> (cur.state == ST_OFF) == $past(cur.powerSync))
        else $error("wrong restart or power-off choice");
    a_off_held: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_OFF && cur.powerSync) |=> powerOff)
        else $error("power-off not held");
    a_reset_held: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_RESET || cur.state == ST_OFF) |-> !periphReset_b)
        else $error("peripheral reset released while in reset");
    a_periph_held: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_POWERUP && !powerUpDone) |=> !periphReset_b)
        else $error("peripheral reset released early");
    a_periph_release: assert property (
        @(posedge clk) disable iff (!rst_b)
        (cur.state == ST_POWERUP && powerUpDone) |=> periphReset_b)
        else $error("peripheral reset not released");
    a_pin_select: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ioCfgValid && ioCfg.pin == IO_CFG_PIN
         && ioCfg.value == IO_CFG_RESET_OUT)
        |=> pinOe && pinOut == periphReset_b)
        else $error("pin not switched to reset output");
    a_pin_release: assert property (
        @(posedge clk) disable iff (!rst_b)
        (ioCfgValid && ioCfg.pin == IO_CFG_PIN
         && ioCfg.value != IO_CFG_RESET_OUT)
        |=> pinOe == gpioOe && pinOut == gpioOut)
        else $error("pin not returned to general io");

endmodule // reset_in_out_sequencer

`default_nettype wire

// file: dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
    // pad pull-up enable from the block
    input  wire logic pullUp,
    // host request to pull the line down
    input  wire logic holdLow,
    // resolved pad level
    output logic      resetReq_b
);
    // open-drain host: pulls low or lets go, never drives high
    assign resetReq_b = holdLow ? 1'b0 : (pullUp ? 1'b1 : 1'bz);
endmodule // host_model

`default_nettype wire

// file: dv/module_reset_in_out_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module module_reset_in_out_sequencer_test;
    import reset_seq_pkg::*;
    // short counts keep the run brief
    localparam int DB = 20;
    localparam int DL = 10;
    logic    clk = 0, rst_b = 0, holdLow = 0, powerOn_b = 0, powerUpDone = 0;
    logic    ioCfgValid = 0, gpioOut = 0, gpioOe = 0;
    io_cfg_s ioCfg = '0;
    wire logic resetReq_b;
    logic    resetReqPullUp, sysResetPulse, memClear, powerOff;
    logic    pinOut, pinOe, periphReset_b;
    int      miscompares = 0, cmp_count = 0, cycles = 0;

    initial forever #12.5 clk = ~clk;

    host_model i_host_model (.pullUp(resetReqPullUp), .holdLow(holdLow),
        .resetReq_b(resetReq_b));
    reset_in_out_sequencer #(.DEBOUNCE_LEN(DB), .DELAY_LEN(DL))
        i_reset_in_out_sequencer (.clk(clk), .rst_b(rst_b),
        .resetReq_b(resetReq_b), .resetReqPullUp(resetReqPullUp),
        .powerOn_b(powerOn_b), .powerUpDone(powerUpDone),
        .ioCfgValid(ioCfgValid), .ioCfg(ioCfg),
        .sysResetPulse(sysResetPulse), .memClear(memClear),
        .powerOff(powerOff), .gpioOut(gpioOut), .gpioOe(gpioOe),
        .pinOut(pinOut), .pinOe(pinOe), .periphReset_b(periphReset_b));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wait_pulse(input int lim, output int n);
        n = 0;
        while (sysResetPulse !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask

    task automatic power_up;
        check(periphReset_b, 1'b0);
        powerUpDone = 1;
        tick(1);
        powerUpDone = 0;
        tick(1);
        check(periphReset_b, 1'b1);
    endtask

    task automatic send_cfg(input logic [7:0] p, input logic [7:0] v);
        ioCfg = '{pin: p, value: v};
        ioCfgValid = 1;
        tick(1);
        ioCfgValid = 0;
        tick(1);
    endtask

    task automatic full_req(input logic pwr);
        int n;
        powerOn_b = pwr;
        // host keeps the line low without a break until the reset lands
        // issued only while the block is otherwise idle
        holdLow = 1;
        wait_pulse(200, n);
        holdLow = 0;
        check(n >= DB + DL && n <= DB + DL + 8, 1'b1);
        check(memClear, 1'b1);
        check({pinOe, pinOut, periphReset_b}, 3'b100);
        n = 0;
        while (sysResetPulse === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(n, 16'(RESET_PULSE_CYCLES));
        tick(2);
        check(powerOff, pwr);
        powerOn_b = 0;
        // power-on level passes two flops before the block acts on it
        tick(3);
        check(powerOff, 1'b0);
        power_up();
        $display("test full request power %0d done", pwr);
    endtask

    task automatic glitch_req;
        int n;
        // two short lows with a gap: neither reaches the debounce length
        holdLow = 1;
        tick(DB - 5);
        holdLow = 0;
        tick(3);
        holdLow = 1;
        tick(DB - 5);
        holdLow = 0;
        wait_pulse(60, n);
        check(n, 16'd60);
        $display("test glitch request done");
    endtask

    task automatic mid_reset;
        // reset arrives while a request is being debounced
        holdLow = 1;
        tick(DB / 2);
        rst_b = 0;
        holdLow = 0;
        tick(3);
        check({sysResetPulse, powerOff, periphReset_b}, 3'b000);
        rst_b = 1;
        tick(2);
        power_up();
        $display("test mid-run reset done");
    endtask

    task automatic io_cfg_test;
        gpioOut = 0;
        gpioOe = 1;
        tick(1);
        check({pinOe, pinOut}, 2'b10);
        send_cfg(IO_CFG_PIN, IO_CFG_RESET_OUT);
        check({pinOe, pinOut}, 2'b11);
        $display("test io config done");
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        tick(5);
        rst_b = 1;
        tick(2);
        check(resetReqPullUp, 1'b1);
        power_up();
        mid_reset();
        io_cfg_test();
        glitch_req();
        full_req(1'b0);
        full_req(1'b1);
        send_cfg(IO_CFG_PIN, 8'h01);
        gpioOut = 1;
        gpioOe = 0;
        tick(1);
        check({pinOe, pinOut}, 2'b01);
        conclude();
    end
endmodule // module_reset_in_out_sequencer_test

`default_nettype wire
